// ### hw/mode_regs_pkg.sv
package mode_regs_pkg;

	localparam logic [1:0] ADDR_LEFT_ATTEN = 2'h0;
	localparam logic [1:0] ADDR_RIGHT_ATTEN = 2'h1;
	localparam logic [1:0] ADDR_FORMAT_CTL = 2'h2;
	localparam logic [1:0] ADDR_SYSTEM_CTL = 2'h3;

	localparam int WORD_BITS = 16;
	localparam int ADDR_HI = 10;
	localparam int ADDR_LO = 9;
	localparam int LOAD_POS = 8;
	localparam int ATTEN_HI = 7;
	localparam int ATTEN_LO = 0;
	localparam int MUTE_POS = 0;
	localparam int DEEMPH_POS = 1;
	localparam int IWL_HI = 4;
	localparam int IWL_LO = 3;
	localparam int OWL_HI = 6;
	localparam int OWL_LO = 5;
	localparam int I2S_POS = 0;
	localparam int POL_POS = 1;
	localparam int COMMON_POS = 2;
	localparam int ROLLOFF_POS = 3;
	localparam int CLKDIV_POS = 5;
	localparam int RATE_HI = 7;
	localparam int RATE_LO = 6;

	localparam logic [7:0] ATTEN_RESET = 8'hff;
	localparam logic [7:0] ATTEN_MUTE_CODE = 8'h00;
	localparam logic [15:0] FORMAT_RESET = 16'h0401;
	localparam logic [15:0] SYSTEM_RESET = 16'h0600;

	typedef enum logic [2:0] {
		IN_STD16, IN_STD20, IN_STD24, IN_LJ24, IN_I2S16, IN_I2S24, IN_RESERVED
	} input_format_t;

	typedef enum logic [1:0] {
		RATE_44K1, RATE_RESERVED, RATE_48K, RATE_32K
	} deemph_rate_t;

	typedef struct packed {
		logic soft_mute_on;
		logic deemphasis_on;
		input_format_t input_format;
		logic [4:0] output_bits;
		logic left_is_high;
		logic rolloff_slow;
		logic clock_out_half;
		deemph_rate_t deemph_rate;
	} filter_config_t;

	typedef struct packed {
		logic [7:0] left;
		logic [7:0] right;
		logic left_mute;
		logic right_mute;
	} atten_out_t;

endpackage

// ### hw/audio_filter_mode_registers.sv
`timescale 1ns/10ps
`default_nettype none
module audio_filter_mode_registers
	import mode_regs_pkg::*;
(
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic ctl_latch,
	input wire logic ctl_shift_clk,
	input wire logic ctl_data,
	output var atten_out_t atten,
	output filter_config_t cfg
);

	// three-stage synchronisers; stage 1 only feeds stage 2
	logic [2:0] sync_latch;
	logic [2:0] sync_clk;
	logic [2:0] sync_data;
	logic latch_q;
	logic clk_q;
	logic data_q;

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			sync_latch <= 3'h7; // idle high, so no false close after reset
			sync_clk <= 3'h0;
			sync_data <= 3'h0;
		end else begin
			sync_latch <= {sync_latch[1:0], ctl_latch};
			sync_clk <= {sync_clk[1:0], ctl_shift_clk};
			sync_data <= {sync_data[1:0], ctl_data};
		end
	end

	// a change counts only once stages two and three agree
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			latch_q <= 1'b1;
			clk_q <= 1'b0;
			data_q <= 1'b0;
		end else begin
			if (sync_latch[1] == sync_latch[2]) latch_q <= sync_latch[2];
			if (sync_clk[1] == sync_clk[2]) clk_q <= sync_clk[2];
			if (sync_data[1] == sync_data[2]) data_q <= sync_data[2];
		end
	end

	logic latch_prev;
	logic clk_prev;
	logic shift_edge;
	logic close_edge;
	assign shift_edge = clk_q && !clk_prev && !latch_q;
	assign close_edge = latch_q && !latch_prev;

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			latch_prev <= 1'b1;
			clk_prev <= 1'b0;
		end else begin
			latch_prev <= latch_q;
			clk_prev <= clk_q;
		end
	end

	// shift register, msb first; counter saturates so extra bits keep last 16
	logic [15:0] shifter;
	logic [4:0] bit_count;

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			shifter <= 16'h0000;
			bit_count <= 5'h00;
		end else if (close_edge) begin
			bit_count <= 5'h00;
		end else if (shift_edge) begin
			shifter <= {shifter[14:0], data_q};
			if (bit_count != 5'(WORD_BITS)) bit_count <= bit_count + 5'h01;
		end
	end

	property p_shift_in;
		@(posedge sys_clk) disable iff (!nrst)
		shift_edge |=> shifter[0] == $past(data_q);
	endproperty
	a_shift_in: assert property (p_shift_in)
		else $error("serial bit not shifted in at lsb");

	property p_count_limit;
		@(posedge sys_clk) disable iff (!nrst)
		bit_count <= 5'(WORD_BITS);
	endproperty
	a_count_limit: assert property (p_count_limit)
		else $error("bit counter passed word length");

	logic word_done;
	assign word_done = close_edge && (bit_count == 5'(WORD_BITS));

	logic [1:0] wr_addr;
	assign wr_addr = shifter[ADDR_HI:ADDR_LO];

	// stored register contents
	logic [7:0] left_atten_value;
	logic [7:0] right_atten_value;
	logic [15:0] format_reg;
	logic [15:0] system_reg;

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			left_atten_value <= ATTEN_RESET;
			right_atten_value <= ATTEN_RESET;
			format_reg <= FORMAT_RESET;
			system_reg <= SYSTEM_RESET;
		end else if (word_done) begin
			unique case (wr_addr)
				ADDR_LEFT_ATTEN: left_atten_value <= shifter[ATTEN_HI:ATTEN_LO];
				ADDR_RIGHT_ATTEN: right_atten_value <= shifter[ATTEN_HI:ATTEN_LO];
				ADDR_FORMAT_CTL: format_reg <= shifter;
				ADDR_SYSTEM_CTL: system_reg <= shifter;
			endcase
		end
	end

	logic common_atten_sel;
	assign common_atten_sel = system_reg[COMMON_POS];

	// applied levels change only on a load; both channels update together
	logic [7:0] new_value;
	logic load_now;
	assign new_value = shifter[ATTEN_HI:ATTEN_LO];
	assign load_now = word_done && shifter[LOAD_POS]
		&& (wr_addr == ADDR_LEFT_ATTEN || wr_addr == ADDR_RIGHT_ATTEN);

	// a store or load is judged one clock after the latch closes the word
	sequence s_short_word;
		close_edge && bit_count != 5'(WORD_BITS);
	endsequence

	sequence s_left_word;
		word_done && wr_addr == ADDR_LEFT_ATTEN;
	endsequence

	sequence s_right_word;
		word_done && wr_addr == ADDR_RIGHT_ATTEN;
	endsequence

	property p_short_atten;
		@(posedge sys_clk) disable iff (!nrst)
		s_short_word |=> $stable(atten);
	endproperty
	a_short_atten: assert property (p_short_atten)
		else $error("attenuation changed on incomplete word");

	property p_short_regs;
		@(posedge sys_clk) disable iff (!nrst)
		s_short_word |=> $stable(format_reg) && $stable(system_reg)
			&& $stable(left_atten_value) && $stable(right_atten_value);
	endproperty
	a_short_regs: assert property (p_short_regs)
		else $error("stored register changed on incomplete word");

	property p_store_left;
		@(posedge sys_clk) disable iff (!nrst)
		s_left_word |=> left_atten_value == $past(new_value);
	endproperty
	a_store_left: assert property (p_store_left)
		else $error("left value not stored");

	property p_store_right;
		@(posedge sys_clk) disable iff (!nrst)
		s_right_word |=> right_atten_value == $past(new_value) && $stable(left_atten_value);
	endproperty
	a_store_right: assert property (p_store_right)
		else $error("right value not stored at its own address");

	property p_store_format;
		@(posedge sys_clk) disable iff (!nrst)
		(word_done && wr_addr == ADDR_FORMAT_CTL) |=> format_reg == $past(shifter);
	endproperty
	a_store_format: assert property (p_store_format)
		else $error("format word not stored");

	logic [7:0] next_left;
	logic [7:0] next_right;
	always_comb begin
		if (wr_addr == ADDR_LEFT_ATTEN) begin
			next_left = new_value;
			next_right = common_atten_sel ? new_value : right_atten_value;
		end else begin
			next_left = left_atten_value;
			next_right = common_atten_sel ? left_atten_value : new_value;
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			atten <= '{ATTEN_RESET, ATTEN_RESET, 1'b0, 1'b0};
		end else if (load_now) begin
			atten.left <= next_left;
			atten.right <= next_right;
			atten.left_mute <= (next_left == ATTEN_MUTE_CODE);
			atten.right_mute <= (next_right == ATTEN_MUTE_CODE);
		end
	end

	property p_common;
		@(posedge sys_clk) disable iff (!nrst)
		(load_now && common_atten_sel) |=> atten.left == atten.right;
	endproperty
	a_common: assert property (p_common)
		else $error("common attenuation not applied");

	property p_noload;
		@(posedge sys_clk) disable iff (!nrst)
		(word_done && !shifter[LOAD_POS]) |=> $stable(atten);
	endproperty
	a_noload: assert property (p_noload)
		else $error("attenuation changed without load");

	property p_mute_left;
		@(posedge sys_clk) disable iff (!nrst)
		atten.left_mute == (atten.left == ATTEN_MUTE_CODE);
	endproperty
	a_mute_left: assert property (p_mute_left)
		else $error("left mute flag mismatch");

	property p_mute_right;
		@(posedge sys_clk) disable iff (!nrst)
		atten.right_mute == (atten.right == ATTEN_MUTE_CODE);
	endproperty
	a_mute_right: assert property (p_mute_right)
		else $error("right mute flag mismatch");

	property p_left_load;
		@(posedge sys_clk) disable iff (!nrst)
		s_left_word ##0 shifter[LOAD_POS] |=> atten.left == $past(new_value);
	endproperty
	a_left_load: assert property (p_left_load)
		else $error("left load not applied");

	property p_left_load_right;
		@(posedge sys_clk) disable iff (!nrst)
		s_left_word ##0 shifter[LOAD_POS] ##0 !common_atten_sel
			|=> atten.right == $past(right_atten_value);
	endproperty
	a_left_load_right: assert property (p_left_load_right)
		else $error("right channel not set from stored right on left load");

	property p_right_load;
		@(posedge sys_clk) disable iff (!nrst)
		s_right_word ##0 shifter[LOAD_POS] ##0 !common_atten_sel
			|=> atten.right == $past(new_value);
	endproperty
	a_right_load: assert property (p_right_load)
		else $error("right load not applied");

	property p_right_load_left;
		@(posedge sys_clk) disable iff (!nrst)
		s_right_word ##0 shifter[LOAD_POS] |=> atten.left == $past(left_atten_value);
	endproperty
	a_right_load_left: assert property (p_right_load_left)
		else $error("left channel not set from stored left on right load");

	function automatic input_format_t decode_format(input logic i2s, input logic [1:0] iw);
		unique case ({i2s, iw})
			3'h0: decode_format = IN_STD16;
			3'h1: decode_format = IN_STD20;
			3'h2: decode_format = IN_STD24;
			3'h3: decode_format = IN_LJ24;
			3'h4: decode_format = IN_I2S16;
			3'h5: decode_format = IN_I2S24;
			default: decode_format = IN_RESERVED;
		endcase
	endfunction

	function automatic logic [4:0] decode_out_bits(input logic [1:0] ow);
		unique case (ow)
			2'h0: decode_out_bits = 5'h10;
			2'h1: decode_out_bits = 5'h12;
			2'h2: decode_out_bits = 5'h14;
			2'h3: decode_out_bits = 5'h18;
		endcase
	endfunction

	// registered so every output comes straight from a flop
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			cfg <= '{1'b0, 1'b0, IN_STD16, 5'h10, 1'b1, 1'b0, 1'b0, RATE_44K1};
		end else begin
			cfg.soft_mute_on <= !format_reg[MUTE_POS];
			cfg.deemphasis_on <= format_reg[DEEMPH_POS];
			cfg.input_format <= decode_format(system_reg[I2S_POS],
				format_reg[IWL_HI:IWL_LO]);
			cfg.output_bits <= decode_out_bits(format_reg[OWL_HI:OWL_LO]);
			cfg.left_is_high <= !system_reg[POL_POS];
			cfg.rolloff_slow <= system_reg[ROLLOFF_POS];
			cfg.clock_out_half <= system_reg[CLKDIV_POS];
			cfg.deemph_rate <= deemph_rate_t'(system_reg[RATE_HI:RATE_LO]);
		end
	end

	property p_mute_bit;
		@(posedge sys_clk) disable iff (!nrst)
		1'b1 |=> cfg.soft_mute_on == !$past(format_reg[MUTE_POS]);
	endproperty
	a_mute_bit: assert property (p_mute_bit)
		else $error("soft mute polarity wrong");

	property p_deemph;
		@(posedge sys_clk) disable iff (!nrst)
		1'b1 |=> cfg.deemphasis_on == $past(format_reg[DEEMPH_POS]);
	endproperty
	a_deemph: assert property (p_deemph)
		else $error("de-emphasis select wrong");

	property p_polarity;
		@(posedge sys_clk) disable iff (!nrst)
		1'b1 |=> cfg.left_is_high == !$past(system_reg[POL_POS]);
	endproperty
	a_polarity: assert property (p_polarity)
		else $error("frame clock polarity wrong");

	property p_rolloff;
		@(posedge sys_clk) disable iff (!nrst)
		1'b1 |=> cfg.rolloff_slow == $past(system_reg[ROLLOFF_POS]);
	endproperty
	a_rolloff: assert property (p_rolloff)
		else $error("roll-off select wrong");

	property p_clkdiv;
		@(posedge sys_clk) disable iff (!nrst)
		1'b1 |=> cfg.clock_out_half == $past(system_reg[CLKDIV_POS]);
	endproperty
	a_clkdiv: assert property (p_clkdiv)
		else $error("clock divide select wrong");

endmodule // audio_filter_mode_registers
`default_nettype wire

// ### verification/host_serial_writer.sv
`timescale 1ns/10ps
`default_nettype none
module host_serial_writer (
	input wire logic sys_clk,
	output logic ctl_latch,
	output logic ctl_shift_clk,
	output logic ctl_data
);
	initial begin
		ctl_latch = 1'b1;
		ctl_shift_clk = 1'b0;
		ctl_data = 1'b0;
	end
	// five clocks a phase, safely above the three-flop sync
	task automatic hold();
		repeat (5) @(posedge sys_clk);
		#1;
	endtask
	// fewer than 16 bits makes a cut-short word
	task automatic send(input logic [15:0] word, input int nbits);
		ctl_latch = 1'b0;
		for (int i = 15; i > 15 - nbits; i--) begin
			ctl_data = word[i];
			hold();
			ctl_shift_clk = 1'b1;
			hold();
			ctl_shift_clk = 1'b0;
		end
		hold();
		ctl_latch = 1'b1;
		hold();
		ctl_data = ~ctl_data;
	endtask
endmodule // host_serial_writer
`default_nettype wire

// ### verification/audio_filter_mode_registers_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module audio_filter_mode_registers_tb_top
	import mode_regs_pkg::*;
;
	logic sys_clk, nrst, ctl_latch, ctl_shift_clk, ctl_data;
	atten_out_t atten;
	filter_config_t cfg;
	int n_fail = 0;
	int checked = 0;
	integer seed = 32'h0000_65a6;
	logic [7:0] st_l = 8'hff, st_r = 8'hff, ap_l = 8'hff, ap_r = 8'hff;
	logic [15:0] fmt = FORMAT_RESET, sys = SYSTEM_RESET;

	audio_filter_mode_registers u_audio_filter_mode_registers (.sys_clk(sys_clk), .nrst(nrst),
		.ctl_latch(ctl_latch), .ctl_shift_clk(ctl_shift_clk), .ctl_data(ctl_data),
		.atten(atten), .cfg(cfg));
	host_serial_writer u_host_serial_writer (.sys_clk(sys_clk), .ctl_latch(ctl_latch),
		.ctl_shift_clk(ctl_shift_clk), .ctl_data(ctl_data));

	function automatic filter_config_t exp_cfg();
		filter_config_t c;
		logic [2:0] f;
		f = {sys[I2S_POS], fmt[IWL_HI:IWL_LO]};
		c.soft_mute_on = ~fmt[MUTE_POS];
		c.deemphasis_on = fmt[DEEMPH_POS];
		c.input_format = f[2] ? (f[1] ? IN_RESERVED : (f[0] ? IN_I2S24 : IN_I2S16))
			: input_format_t'(f);
		c.output_bits = fmt[6] ? (fmt[5] ? 5'h18 : 5'h14) : (fmt[5] ? 5'h12 : 5'h10);
		c.left_is_high = ~sys[POL_POS];
		c.rolloff_slow = sys[ROLLOFF_POS];
		c.clock_out_half = sys[CLKDIV_POS];
		c.deemph_rate = deemph_rate_t'(sys[RATE_HI:RATE_LO]);
		return c;
	endfunction

	task automatic check_all(input string what);
		atten_out_t ea;
		filter_config_t ec;
		ea = '{ap_l, ap_r, ap_l == 8'h00, ap_r == 8'h00};
		ec = exp_cfg();
		checked += 2;
		if (atten !== ea) begin
			n_fail++;
			$display("CHECK FAILED atten %s expected %h seen %h", what, ea, atten);
		end
		if (cfg !== ec) begin
			n_fail++;
			$display("CHECK FAILED cfg %s expected %h seen %h", what, ec, cfg);
		end
	endtask

	// reserved bits cleared so only documented fields move
	task automatic write_reg(input logic [1:0] a, input logic [15:0] v, input int nbits);
		logic [15:0] w;
		logic [8:0] m;
		m = a[1] ? (a[0] ? 9'h0ef : 9'h07b) : 9'h1ff;
		w = {5'h00, a, v[8:0] & m};
		u_host_serial_writer.send(w, nbits);
		repeat (12) @(posedge sys_clk);
		#1;
		if (nbits == 16) begin
			case (a)
				2'h0: st_l = w[7:0];
				2'h1: st_r = w[7:0];
				2'h2: fmt = w;
				default: sys = w;
			endcase
			if (a[1] == 1'b0 && w[LOAD_POS]) begin
				ap_l = st_l;
				ap_r = sys[COMMON_POS] ? st_l : st_r;
			end
		end
		check_all($sformatf("addr %0d word %h", a, w));
	endtask

	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end

	initial begin
		repeat (40000) @(posedge sys_clk);
		n_fail++;
		$display("CHECK FAILED watchdog expected finish seen hang");
		stop_test();
	end

	initial begin
		nrst = 1'b0;
		repeat (8) @(posedge sys_clk);
		#1;
		nrst = 1'b1;
		repeat (6) @(posedge sys_clk);
		#1;
		write_reg(2'h0, 16'h0012, 16);
		write_reg(2'h1, 16'h0034, 16);
		write_reg(2'h0, 16'h01aa, 12);
		write_reg(2'h3, 16'h0004, 16);
		write_reg(2'h1, 16'h0156, 16);
		write_reg(2'h3, 16'h0000, 16);
		write_reg(2'h1, 16'h0177, 16);
		write_reg(2'h0, 16'h0100, 16);
		$display("directed test done");
		// random mix of 90 full-length writes with random addresses and values
		repeat (90) write_reg(2'($random(seed)), 16'($random(seed)), 16);
		$display("random test done");
		stop_test();
	end
endmodule // audio_filter_mode_registers_tb_top
`default_nettype wire
